// ===== scp_dev.sv
// device end of the serial config register port: target logic and register array
// assumes scl and sda arrive asynchronously through scp_if; strap is a pin
`timescale 1ns/1ns
module scp_dev #(
   parameter int unsigned FILT = scp_pkg::SCL_FILT_PERIODS,
   parameter int unsigned NREGS = scp_pkg::NREGS
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   scp_if.dev bus,
   input wire logic i_addr_sel,
   output logic o_wr_stb,
   output logic [scp_pkg::BYTE_W-1:0] o_wr_addr,
   output logic [scp_pkg::BYTE_W-1:0] o_wr_data,
   output logic o_selected
);
   import scp_pkg::*;

   if (FILT < 2 || FILT > 15 || NREGS < 1 || NREGS > 256) begin : g_bad_param
      $error("scp_dev: FILT must be 2..15 and NREGS 1..256");
   end

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REG,
      ST_REG_ACK,
      ST_WDATA,
      ST_WACK,
      ST_RDATA,
      ST_RACK
   } scp_dst_t;

   logic scl_s1_r;
   logic scl_s2_r;
   logic sda_s1_r;
   logic sda_s2_r;
   logic sel_s1_r;
   logic sel_s2_r;
   logic [3:0] filt_cnt_r;
   logic scl_f_r;
   logic scl_p_r;
   logic [FILT-1:0] sda_dly_r;
   logic sda_p_r;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic wr_now;
   scp_dst_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic rw_r;
   logic [7:0] ptr_r;
   logic oe_r;
   logic mack_r;
   logic [7:0] rd_cur;
   logic [7:0] regs [0:NREGS-1];

   // reads past the array return zero rather than wrapping onto real registers
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      if ({1'b0, a} < 9'(NREGS)) begin
         return regs[a];
      end
      return 8'h00;
   endfunction : rd_byte

   // a function result cannot be bit-selected, so the byte gets its own net
   always_comb rd_cur = rd_byte(ptr_r);

   // pin synchronisers; first stages feed nothing but the second
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sel_s1_r <= 1'b0;
         sel_s2_r <= 1'b0;
      end else begin
         scl_s1_r <= bus.scl;
         scl_s2_r <= scl_s1_r;
         sda_s1_r <= bus.sda;
         sda_s2_r <= sda_s1_r;
         sel_s1_r <= i_addr_sel;
         sel_s2_r <= sel_s1_r;
      end
   end

   // scl only moves after FILT matching samples, so short spikes vanish
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         filt_cnt_r <= 4'h0;
         scl_f_r <= 1'b1;
      end else if (scl_s2_r == scl_f_r) begin
         filt_cnt_r <= 4'h0;
      end else if (filt_cnt_r == 4'(FILT - 1)) begin
         scl_f_r <= scl_s2_r;
         filt_cnt_r <= 4'h0;
      end else begin
         filt_cnt_r <= filt_cnt_r + 4'h1;
      end
   end

   // sda gets the same delay so start and stop keep their order against scl
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sda_dly_r <= '1;
         sda_p_r <= 1'b1;
         scl_p_r <= 1'b1;
      end else begin
         sda_dly_r <= {sda_dly_r[FILT-2:0], sda_s2_r};
         sda_p_r <= sda_d;
         scl_p_r <= scl_f_r;
      end
   end

   assign sda_d = sda_dly_r[FILT-1];
   assign scl_rise = scl_f_r & ~scl_p_r;
   assign scl_fall = ~scl_f_r & scl_p_r;
   assign start_ev = scl_f_r & scl_p_r & sda_p_r & ~sda_d;
   assign stop_ev = scl_f_r & scl_p_r & ~sda_p_r & sda_d;
   assign wr_now = scl_fall && state_r == ST_WDATA && cnt_r == BIT_ACK;

   // transfer engine, moves only on filtered scl edges and bus conditions
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         ptr_r <= PTR_RST;
         oe_r <= 1'b0;
         mack_r <= 1'b0;
      end else if (start_ev) begin
         state_r <= ST_ADDR;
         cnt_r <= 4'h0;
         oe_r <= 1'b0;
      end else if (stop_ev) begin
         state_r <= ST_IDLE;
         oe_r <= 1'b0;
      end else if (scl_rise) begin
         case (state_r)
            ST_ADDR, ST_REG, ST_WDATA: begin
               sh_r <= {sh_r[6:0], sda_d};
               cnt_r <= cnt_r + 4'h1;
            end
            ST_RDATA: begin
               cnt_r <= cnt_r + 4'h1;
            end
            ST_RACK: begin
               mack_r <= ~sda_d;
            end
            default: begin
               cnt_r <= cnt_r;
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            ST_IDLE: begin
               oe_r <= 1'b0;
            end
            ST_ADDR: begin
               if (cnt_r == BIT_ACK) begin
                  if (sh_r[7:1] == {ADDR_HI, sel_s2_r}) begin
                     rw_r <= sh_r[0];
                     oe_r <= 1'b1;
                     state_r <= ST_ADDR_ACK;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               cnt_r <= 4'h0;
               if (rw_r) begin
                  sh_r <= rd_cur;
                  oe_r <= ~rd_cur[7];
                  state_r <= ST_RDATA;
               end else begin
                  oe_r <= 1'b0;
                  state_r <= ST_REG;
               end
            end
            ST_REG: begin
               if (cnt_r == BIT_ACK) begin
                  ptr_r <= sh_r;
                  oe_r <= 1'b1;
                  state_r <= ST_REG_ACK;
               end
            end
            ST_REG_ACK: begin
               oe_r <= 1'b0;
               cnt_r <= 4'h0;
               state_r <= ST_WDATA;
            end
            ST_WDATA: begin
               if (cnt_r == BIT_ACK) begin
                  ptr_r <= ptr_r + 8'h01;
                  oe_r <= 1'b1;
                  state_r <= ST_WACK;
               end
            end
            ST_WACK: begin
               oe_r <= 1'b0;
               cnt_r <= 4'h0;
               state_r <= ST_WDATA;
            end
            ST_RDATA: begin
               if (cnt_r == BIT_ACK) begin
                  oe_r <= 1'b0;
                  ptr_r <= ptr_r + 8'h01;
                  state_r <= ST_RACK;
               end else begin
                  sh_r <= {sh_r[6:0], 1'b0};
                  oe_r <= ~sh_r[6];
               end
            end
            ST_RACK: begin
               if (mack_r) begin
                  sh_r <= rd_cur;
                  oe_r <= ~rd_cur[7];
                  cnt_r <= 4'h0;
                  state_r <= ST_RDATA;
               end else begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               oe_r <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // the array has no reset; contents are undefined until written
   always_ff @(posedge i_clock) begin
      if (wr_now && {1'b0, ptr_r} < 9'(NREGS)) begin
         regs[ptr_r] <= sh_r;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wr_stb <= 1'b0;
         o_wr_addr <= 8'h00;
         o_wr_data <= 8'h00;
         o_selected <= 1'b0;
      end else begin
         o_wr_stb <= wr_now;
         o_selected <= state_r != ST_IDLE;
         if (wr_now) begin
            o_wr_addr <= ptr_r;
            o_wr_data <= sh_r;
         end
      end
   end

   // open drain: only ever pulls low, enable carries the data
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = oe_r;
endmodule : scp_dev

// ===== scp_pkg.sv
// constants shared by both ends of the serial config register port
// assumes a 10 MHz system clock on both ends
package scp_pkg;
   localparam int unsigned BYTE_W = 8;
   // fixed upper six address bits, lowest bit comes from the strap
   localparam logic [5:0] ADDR_HI = 6'h26;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam int unsigned SCL_FILT_PERIODS = 3;
   localparam int unsigned NREGS = 256;
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned HOST_SCL_NS = 4000;
   localparam int unsigned HOST_QTR_CYC = HOST_SCL_NS / (4 * CLK_NS);
   localparam logic [7:0] PTR_RST = 8'h00;
endpackage : scp_pkg

// ===== scp_if.sv
// two-wire link between host and device ends
// sda is open drain: the wire is low while either end enables a low output
`timescale 1ns/1ns
interface scp_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;

   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev (
      input scl,
      input sda,
      output dev_sda_o,
      output dev_sda_oe
   );

   modport host (
      output scl,
      output host_sda_o,
      output host_sda_oe,
      input sda
   );
endinterface : scp_if

// ===== scp_host.sv
// host end of the serial config register port: bus controller making scl
// assumes one command at a time from user logic on the same clock
`timescale 1ns/1ns
module scp_host #(
   parameter int unsigned QTR = scp_pkg::HOST_QTR_CYC
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   scp_if.host bus,
   input wire logic i_dev_sel,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic i_cmd_read,
   input wire logic [7:0] i_cmd_reg,
   input wire logic [7:0] i_cmd_len,
   input wire logic [7:0] i_wr_data,
   output logic o_wr_take,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_done,
   output logic o_nack
);
   import scp_pkg::*;

   // below 8 the device ack may not settle before the host samples it
   if (QTR < 8 || QTR > 255) begin : g_bad_param
      $error("scp_host: QTR must be 8..255");
   end

   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} scp_hst_t;
   typedef enum logic [2:0] {K_ADDRW, K_REG, K_WDATA, K_ADDRR, K_RDATA} scp_knd_t;

   scp_hst_t state_r;
   scp_knd_t kind_r;
   logic [7:0] tcnt_r;
   logic tick;
   logic [1:0] q_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] left_r;
   logic [7:0] reg_r;
   logic rd_r;
   logic sel_r;
   logic restart_r;
   logic scl_r;
   logic oe_r;
   logic nack_r;
   logic sda_s1_r;
   logic sda_s2_r;
   logic ack;

   assign tick = tcnt_r == 8'(QTR - 1);
   assign ack = ~sda_s2_r;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
      end else begin
         sda_s1_r <= bus.sda;
         sda_s2_r <= sda_s1_r;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         tcnt_r <= 8'h00;
      end else if (state_r == H_IDLE || tick) begin
         tcnt_r <= 8'h00;
      end else begin
         tcnt_r <= tcnt_r + 8'h01;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= H_IDLE;
         kind_r <= K_ADDRW;
         q_r <= 2'h0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         left_r <= 8'h00;
         reg_r <= 8'h00;
         rd_r <= 1'b0;
         sel_r <= 1'b0;
         restart_r <= 1'b0;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
         nack_r <= 1'b0;
         o_cmd_ready <= 1'b1;
         o_wr_take <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= 8'h00;
         o_done <= 1'b0;
         o_nack <= 1'b0;
      end else begin
         o_wr_take <= 1'b0;
         o_rd_valid <= 1'b0;
         o_done <= 1'b0;
         case (state_r)
            H_IDLE: begin
               scl_r <= 1'b1;
               oe_r <= 1'b0;
               if (i_cmd_valid) begin
                  o_cmd_ready <= 1'b0;
                  rd_r <= i_cmd_read;
                  reg_r <= i_cmd_reg;
                  sel_r <= i_dev_sel;
                  left_r <= (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
                  sh_r <= {ADDR_HI, i_dev_sel, 1'b0};
                  kind_r <= K_ADDRW;
                  restart_r <= 1'b0;
                  nack_r <= 1'b0;
                  q_r <= 2'h0;
                  state_r <= H_START;
               end
            end
            H_START: begin
               if (tick) begin
                  q_r <= q_r + 2'h1;
                  case (q_r)
                     2'h0: scl_r <= restart_r ? 1'b0 : scl_r;
                     2'h1: oe_r <= 1'b0;
                     2'h2: scl_r <= 1'b1;
                     default: begin
                        oe_r <= 1'b1;
                        bit_r <= 4'h0;
                        state_r <= H_BYTE;
                     end
                  endcase
               end
            end
            H_BYTE: begin
               if (tick) begin
                  q_r <= q_r + 2'h1;
                  case (q_r)
                     2'h0: scl_r <= 1'b0;
                     2'h1: begin
                        // sda only moves mid-low, well clear of both scl edges
                        if (bit_r != BIT_ACK) begin
                           oe_r <= (kind_r == K_RDATA) ? 1'b0 : ~sh_r[7];
                        end else begin
                           oe_r <= (kind_r == K_RDATA) && left_r != 8'h01;
                        end
                     end
                     2'h2: scl_r <= 1'b1;
                     default: begin
                        if (bit_r != BIT_ACK) begin
                           sh_r <= {sh_r[6:0], (kind_r == K_RDATA) ? sda_s2_r : 1'b0};
                           bit_r <= bit_r + 4'h1;
                        end else begin
                           bit_r <= 4'h0;
                           case (kind_r)
                              K_ADDRW: begin
                                 if (!ack) begin
                                    nack_r <= 1'b1;
                                    state_r <= H_STOP;
                                 end else begin
                                    sh_r <= reg_r;
                                    kind_r <= K_REG;
                                 end
                              end
                              K_REG: begin
                                 if (!ack) begin
                                    nack_r <= 1'b1;
                                    state_r <= H_STOP;
                                 end else if (rd_r) begin
                                    restart_r <= 1'b1;
                                    sh_r <= {ADDR_HI, sel_r, 1'b1};
                                    kind_r <= K_ADDRR;
                                    state_r <= H_START;
                                 end else begin
                                    sh_r <= i_wr_data;
                                    o_wr_take <= 1'b1;
                                    kind_r <= K_WDATA;
                                 end
                              end
                              K_WDATA: begin
                                 if (!ack) begin
                                    nack_r <= 1'b1;
                                    state_r <= H_STOP;
                                 end else if (left_r == 8'h01) begin
                                    state_r <= H_STOP;
                                 end else begin
                                    left_r <= left_r - 8'h01;
                                    sh_r <= i_wr_data;
                                    o_wr_take <= 1'b1;
                                 end
                              end
                              K_ADDRR: begin
                                 if (!ack) begin
                                    nack_r <= 1'b1;
                                    state_r <= H_STOP;
                                 end else begin
                                    kind_r <= K_RDATA;
                                 end
                              end
                              default: begin
                                 o_rd_valid <= 1'b1;
                                 o_rd_data <= sh_r;
                                 left_r <= left_r - 8'h01;
                                 if (left_r == 8'h01) begin
                                    state_r <= H_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  q_r <= q_r + 2'h1;
                  case (q_r)
                     2'h0: scl_r <= 1'b0;
                     2'h1: oe_r <= 1'b1;
                     2'h2: scl_r <= 1'b1;
                     default: begin
                        oe_r <= 1'b0;
                        o_done <= 1'b1;
                        o_nack <= nack_r;
                        o_cmd_ready <= 1'b1;
                        state_r <= H_IDLE;
                     end
                  endcase
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   assign bus.scl = scl_r;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = oe_r;
endmodule : scp_host

// ===== scp_sva.sv
// assertions on the host-to-device two-wire link
// assumes both ends run on i_clock and the strap is steady during transfers
`timescale 1ns/1ns
module scp_sva (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic i_addr_sel
);
   import scp_pkg::*;
   logic scl_d_r, sda_d_r, on_r, ok_r, rd_r;
   logic [3:0] bit_r;
   logic [1:0] byte_r;
   logic [7:0] sh_r;
   wire rise = scl & ~scl_d_r;
   wire start = scl & scl_d_r & sda_d_r & ~sda;
   wire stop = scl & scl_d_r & ~sda_d_r & sda;
   wire hit = sh_r[7:1] == {ADDR_HI, i_addr_sel};
   wire ack_slot = rise && bit_r == 4'h8;

   // bit and byte position since the last start, raw scl seen by i_clock
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_d_r <= 1'h1;
         sda_d_r <= 1'h1;
         bit_r <= 4'h0;
         byte_r <= 2'h0;
         on_r <= 1'h0;
      end else begin
         scl_d_r <= scl;
         sda_d_r <= sda;
         if (start) begin
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            on_r <= 1'h1;
         end else if (ack_slot) begin
            bit_r <= 4'h0;
            byte_r <= (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
         end else if (rise) begin
            bit_r <= bit_r + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sh_r <= 8'h00;
      end else if (rise && !ack_slot) begin
         sh_r <= {sh_r[6:0], sda};
      end
   end

   // outcome of the address byte, kept until the next start
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ok_r <= 1'h0;
         rd_r <= 1'h0;
      end else if (start) begin
         ok_r <= 1'h0;
      end else if (ack_slot && byte_r == 2'h0) begin
         ok_r <= hit;
         rd_r <= sh_r[0];
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   addr_ack_a: assert property (ack_slot && byte_r == 2'h0 |-> sda == !hit)
      else $error("address ack wrong");
   write_ack_a: assert property (ack_slot && byte_r != 2'h0 && ok_r && !rd_r |-> !sda)
      else $error("written byte not acked");
   read_ack_a: assert property (ack_slot && ok_r && rd_r |-> !dev_sda_oe)
      else $error("device drove read ack slot");
   drive_scope_a: assert property ($rose(dev_sda_oe) |-> hit || ok_r)
      else $error("device drove sda unaddressed");
   quiet_start_a: assert property (!on_r |-> !dev_sda_oe)
      else $error("device drove sda before start");
   dev_change_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 4))
      else $error("device sda moved too early");
   bit_hold_a: assert property (rise |=> $stable(sda)[*8])
      else $error("sda moved while scl high");
   stop_idle_a: assert property (stop |=> (scl && sda && !host_sda_oe && !dev_sda_oe)[*4])
      else $error("bus not idle after stop");

   cover property (ack_slot && byte_r == 2'h0 && !hit);
   cover property (ack_slot && ok_r && rd_r);
   cover property (start && on_r);
endmodule : scp_sva

// ===== scp_bench.sv
// bench: host and device ends joined, plus a second device driven by hand
// assumes package defaults; inputs change on the falling clock edge
`timescale 1ns/1ns
module scp_bench;
   import scp_pkg::*;
   logic i_clock = 1'h0;
   logic i_resetn = 1'h0;
   logic strap = 1'h0;
   logic dev_sel = 1'h0;
   logic valid = 1'h0;
   logic rd = 1'h0;
   logic [7:0] rg = 8'h00;
   logic [7:0] len = 8'h00;
   logic [7:0] wd = 8'h00;
   logic ready, take, rdv, done, nack, stb, sel, b_sel, ack;
   logic [7:0] rdd, wa, wb, b_a, b_d;
   logic [7:0] wq[$];
   logic [15:0] sq[$];
   logic [7:0] rq[$];
   int err_total = 0;
   int checks = 0;
   scp_if bus ();
   scp_if bus_b ();

   always #50 i_clock = ~i_clock;

   scp_host scp_host_i (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus.host),
      .i_dev_sel(dev_sel), .i_cmd_valid(valid), .o_cmd_ready(ready), .i_cmd_read(rd),
      .i_cmd_reg(rg), .i_cmd_len(len), .i_wr_data(wd), .o_wr_take(take), .o_rd_valid(rdv),
      .o_rd_data(rdd), .o_done(done), .o_nack(nack));
   scp_dev scp_dev_i (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus.dev),
      .i_addr_sel(strap), .o_wr_stb(stb), .o_wr_addr(wa), .o_wr_data(wb), .o_selected(sel));
   scp_dev scp_dev_b_i (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus_b.dev),
      .i_addr_sel(1'h0), .o_wr_stb(), .o_wr_addr(b_a), .o_wr_data(b_d), .o_selected(b_sel));
   scp_sva scp_sva_i (.i_clock(i_clock), .i_resetn(i_resetn), .scl(bus.scl), .sda(bus.sda),
      .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe), .i_addr_sel(strap));

   always @(negedge i_clock) begin
      if (take === 1'h1 && wq.size() > 0)
         wd <= wq.pop_front();
      if (stb === 1'h1)
         sq.push_back({wa, wb});
      if (rdv === 1'h1)
         rq.push_back(rdd);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // gap first, so the bus rests idle between transfers
   task automatic cmd(input logic r, input logic [7:0] a, input logic [7:0] n);
      int k;
      k = 0;
      repeat (8) @(negedge i_clock);
      check({15'h0, sel}, 16'h0);
      if (wq.size() > 0)
         wd = wq.pop_front();
      rd = r;
      rg = a;
      len = n;
      valid = 1'h1;
      @(negedge i_clock);
      valid = 1'h0;
      while (done !== 1'h1 && k < 30000) begin
         @(negedge i_clock);
         k++;
      end
      check({15'h0, done}, 16'h1);
      check({15'h0, ready}, 16'h1);
   endtask : cmd

   task automatic stb_chk(input logic [7:0] a, input logic [7:0] d);
      check((sq.size() > 0) ? sq.pop_front() : 16'hxxxx, {a, d});
   endtask : stb_chk

   task automatic rd_chk(input logic [7:0] d);
      check((rq.size() > 0) ? {8'h00, rq.pop_front()} : 16'hxxxx, {8'h00, d});
   endtask : rd_chk

   // one bit on the hand link; gl adds a low pulse the filter must swallow
   task automatic bb_bit(input logic b, input logic gl, output logic s);
      bus_b.scl = 1'h0;
      repeat (10) @(negedge i_clock);
      bus_b.host_sda_oe = ~b;
      repeat (10) @(negedge i_clock);
      bus_b.scl = 1'h1;
      repeat (6) @(negedge i_clock);
      if (gl) begin
         bus_b.scl = 1'h0;
         repeat (2) @(negedge i_clock);
         bus_b.scl = 1'h1;
      end
      repeat (6) @(negedge i_clock);
      s = bus_b.sda;
   endtask : bb_bit

   task automatic bb_byte(input logic [7:0] v, input logic gl);
      logic s;
      for (int i = 7; i >= 0; i--)
         bb_bit(v[i], gl, s);
      bb_bit(1'h1, gl, ack);
   endtask : bb_byte

   initial begin
      repeat (40000) @(negedge i_clock);
      err_total++;
      results();
   end

   initial begin
      bus_b.scl = 1'h1;
      bus_b.host_sda_o = 1'h0;
      bus_b.host_sda_oe = 1'h0;
      repeat (16) @(negedge i_clock);
      i_resetn = 1'h1;
      // three writes from the second-highest register, pointer wraps to zero
      wq = '{8'ha5, 8'h5a, 8'hc3};
      cmd(1'h0, 8'hfe, 8'h03);
      check({15'h0, nack}, 16'h0);
      stb_chk(8'hfe, 8'ha5);
      stb_chk(8'hff, 8'h5a);
      stb_chk(8'h00, 8'hc3);
      cmd(1'h1, 8'hfe, 8'h03);
      rd_chk(8'ha5);
      rd_chk(8'h5a);
      rd_chk(8'hc3);
      check(16'(sq.size()), 16'h0);
      // device moves to the odd address, host still aims at the even one
      strap = 1'h1;
      cmd(1'h0, 8'h40, 8'h00);
      check({15'h0, nack}, 16'h1);
      check(16'(sq.size()), 16'h0);
      dev_sel = 1'h1;
      wq = '{8'h3c};
      cmd(1'h0, 8'h40, 8'h00);
      check({15'h0, nack}, 16'h0);
      stb_chk(8'h40, 8'h3c);
      cmd(1'h1, 8'h40, 8'h00);
      rd_chk(8'h3c);
      // bits clocked before any start must not wake the device
      bb_byte(8'h98, 1'h0);
      check({15'h0, ack}, 16'h1);
      check({15'h0, b_sel}, 16'h0);
      bus_b.host_sda_oe = 1'h1;
      repeat (10) @(negedge i_clock);
      bb_byte(8'h98, 1'h1);
      check({15'h0, ack}, 16'h0);
      check({15'h0, b_sel}, 16'h1);
      bb_byte(8'h07, 1'h1);
      check({15'h0, ack}, 16'h0);
      bb_byte(8'h81, 1'h1);
      check({15'h0, ack}, 16'h0);
      bus_b.scl = 1'h0;
      repeat (10) @(negedge i_clock);
      bus_b.host_sda_oe = 1'h1;
      repeat (10) @(negedge i_clock);
      bus_b.scl = 1'h1;
      repeat (10) @(negedge i_clock);
      bus_b.host_sda_oe = 1'h0;
      repeat (10) @(negedge i_clock);
      check({b_a, b_d}, 16'h0781);
      check({15'h0, b_sel}, 16'h0);
      results();
   end
endmodule : scp_bench
